// *** ost_settle_timer.sv ***
// Crystal settle timer with status and select registers on the CPU byte bus.
// Assumes crystal pin sampled in SYS_CLK domain; standby control gives one-cycle events.
//
// Rules for this block and for the software that drives it
// R01: Status register shows settle counter progress
// R02: Status is read-only, bit or byte reads
// R03: Resets, stop entry, oscillator halt clear status
// R04: Flags set at 2^11,13,14,15,16 crystal cycles
// R05: Flags set in order and stay set
// R06: Counting ends at the selected wait
// R07: Crystal CPU clock held until wait ends
// R08: Software polls status on internal clock
// R09: Select is byte-written, resets to 0x05
// R10: Select codes 1..5 map to waits
// R11: Software programs select before stop entry
// R12: Select unchanged during a settle interval
// R13: Select wait covers the checked milestone
// R14: Counting starts once crystal really oscillates
// R15: Counter advances on crystal cycles only
`timescale 1ns/1ps
module ost_settle_timer (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // CPU register access
  input wire ost_pkg::ost_bus_req_t BUS_REQ,
  output logic [7:0] BUS_RDATA,
  output logic BUS_RVALID,
  // Clock and standby control
  input wire logic CRYSTAL_PIN,
  input wire logic STOP_ENTRY,
  input wire logic STOP_RELEASE,
  input wire logic MAIN_OSC_HALT,
  input wire ost_pkg::ost_cpu_clk_t CPU_CLK_SEL,
  // Status to the clock generator
  output logic CPU_HOLD,
  output logic SETTLE_DONE
);
  import ost_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [OST_CNT_W-1:0] sel_limit(input logic [2:0] sel);
    case (sel)
      3'h1: sel_limit = OST_CNT_W'(1) << OST_EXP_0;
      3'h2: sel_limit = OST_CNT_W'(1) << OST_EXP_1;
      3'h3: sel_limit = OST_CNT_W'(1) << OST_EXP_2;
      3'h4: sel_limit = OST_CNT_W'(1) << OST_EXP_3;
      default: sel_limit = OST_CNT_W'(1) << OST_EXP_4;
    endcase
  endfunction

  function automatic logic [OST_CNT_W-1:0] flag_limit(input int idx);
    case (idx)
      0: flag_limit = OST_CNT_W'(1) << OST_EXP_0;
      1: flag_limit = OST_CNT_W'(1) << OST_EXP_1;
      2: flag_limit = OST_CNT_W'(1) << OST_EXP_2;
      3: flag_limit = OST_CNT_W'(1) << OST_EXP_3;
      default: flag_limit = OST_CNT_W'(1) << OST_EXP_4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Crystal edges
  logic xtal_rise;

  ost_edge_sync u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .pin(CRYSTAL_PIN),
    .rise(xtal_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter state
  typedef enum logic [1:0] {OST_IDLE, OST_WAKE, OST_COUNT, OST_DONE} ost_state_t;

  ost_state_t state_r, state_nxt;
  logic [OST_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] alive_r, alive_nxt;
  logic [OST_FLAGS-1:0] flags_r, flags_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic hold_r, hold_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [OST_CNT_W-1:0] limit;
  logic clear_ev;
  logic [7:0] status_byte;

  always_comb begin
    limit = sel_limit(sel_r);
    clear_ev = STOP_ENTRY | MAIN_OSC_HALT; // R03
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    alive_nxt = alive_r;
    flags_nxt = flags_r;
    hold_nxt = hold_r;
    case (state_r)
      OST_IDLE: begin
        if (xtal_rise && !MAIN_OSC_HALT) begin
          alive_nxt = 3'h1;
          state_nxt = OST_WAKE;
        end
      end
      OST_WAKE: begin
        // Start-up edges before steady oscillation are not counted
        if (xtal_rise) begin // R14
          alive_nxt = alive_r + 3'h1;
          if (alive_r == 3'(OST_OSC_ALIVE_EDGES - 1)) begin
            state_nxt = OST_COUNT;
          end
        end
      end
      OST_COUNT: begin
        if (xtal_rise) begin // R15
          cnt_nxt = cnt_r + OST_CNT_W'(1);
          if (cnt_nxt >= limit) begin // R06
            state_nxt = OST_DONE;
          end
        end
      end
      OST_DONE: begin
        hold_nxt = 1'b0; // R07
      end
      default: state_nxt = OST_IDLE;
    endcase
    for (int i = 0; i < OST_FLAGS; i++) begin
      // Sticky, thermometer order since limits grow with index
      if (cnt_nxt >= flag_limit(i)) begin // R04 R05
        flags_nxt[OST_FLAGS-1-i] = 1'b1;
      end
    end
    if (STOP_RELEASE && CPU_CLK_SEL == OST_CLK_CRYSTAL) begin
      hold_nxt = (state_nxt != OST_DONE); // R07
    end
    if (clear_ev) begin // R03
      state_nxt = OST_IDLE;
      cnt_nxt = '0;
      alive_nxt = '0;
      flags_nxt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers: select is byte-write only, status is read only
  always_comb begin
    status_byte = {3'h0, flags_r}; // R01
    sel_nxt = sel_r;
    if (BUS_REQ.wr && !BUS_REQ.bit_acc && BUS_REQ.addr == OST_ADDR_SELECT) begin // R09
      sel_nxt = BUS_REQ.wdata[2:0]; // R10
    end
    rdata_nxt = 8'h00;
    rvalid_nxt = BUS_REQ.rd;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        OST_ADDR_STATUS: rdata_nxt = status_byte; // R02
        OST_ADDR_SELECT: rdata_nxt = {5'h00, sel_r};
        default: rdata_nxt = 8'h00;
      endcase
      if (BUS_REQ.bit_acc) begin // R02
        rdata_nxt = {7'h00, rdata_nxt[BUS_REQ.bit_pos]};
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_r <= OST_IDLE;
      cnt_r <= '0;
      alive_r <= '0;
      flags_r <= '0; // R03
      sel_r <= OST_SELECT_RST[2:0]; // R09
      hold_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      alive_r <= alive_nxt;
      flags_r <= flags_nxt;
      sel_r <= sel_nxt;
      hold_r <= hold_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign BUS_RDATA = rdata_r;
  assign BUS_RVALID = rvalid_r;
  assign CPU_HOLD = hold_r;
  logic done_r;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_nxt == OST_DONE);
    end
  end
  assign SETTLE_DONE = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CLEAR_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (STOP_ENTRY | MAIN_OSC_HALT) |=> flags_r == '0) else $error("status not cleared"); // R03
  AST_THERMO: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    flags_r inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f}) else $error("flags out of order"); // R05
  AST_STICKY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !clear_ev |=> (flags_r & $past(flags_r)) == $past(flags_r)) else $error("flag dropped"); // R05
  AST_FIRST_AT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(flags_r[4]) |-> cnt_r == (OST_CNT_W'(1) << OST_EXP_0)) else $error("first flag wrong time"); // R04
  AST_STOP_LIMIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (state_r == OST_COUNT && $stable(sel_r)) |-> cnt_r < limit) else $error("count past select"); // R06
  AST_SEL_RESET: assert property (@(posedge SYS_CLK)
    !RST_N |=> sel_r == 3'h5) else $error("select reset value"); // R09
  AST_NO_WRITE_STATUS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (BUS_REQ.wr && BUS_REQ.addr == OST_ADDR_STATUS && !clear_ev && !xtal_rise) |=> $stable(flags_r))
    else $error("status written"); // R02
  AST_HOLD_RELEASE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (state_r == OST_DONE && !STOP_RELEASE && !clear_ev) |=> !hold_r) else $error("hold stuck"); // R07
  AST_NO_COUNT_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_r == OST_IDLE |=> cnt_r == '0) else $error("counted before oscillation"); // R14

endmodule

// *** ost_pkg.sv ***
// Package for the crystal settle timer: register map, fields, reset values, milestones.
// Assumes one system clock; the crystal arrives as a sampled pin level.
package ost_pkg;

  localparam logic [15:0] OST_ADDR_STATUS = 16'hffa3;
  localparam logic [15:0] OST_ADDR_SELECT = 16'hffa4;
  localparam logic [7:0] OST_STATUS_RST = 8'h00;
  localparam logic [7:0] OST_SELECT_RST = 8'h05;
  localparam int OST_SEL_W = 3;
  localparam int OST_FLAGS = 5;
  localparam int OST_CNT_W = 17;
  localparam int OST_OSC_ALIVE_EDGES = 4;

  // Milestone exponents, index 0 is the shortest wait
  localparam int OST_EXP_0 = 11;
  localparam int OST_EXP_1 = 13;
  localparam int OST_EXP_2 = 14;
  localparam int OST_EXP_3 = 15;
  localparam int OST_EXP_4 = 16;

  // Select codes
  localparam logic [2:0] OST_SEL_MIN = 3'h1;
  localparam logic [2:0] OST_SEL_MAX = 3'h5;

  // CPU bus request and CPU clock source
  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_acc;
    logic [2:0] bit_pos;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ost_bus_req_t;

  typedef enum logic [1:0] {OST_CLK_HIGH_INT, OST_CLK_CRYSTAL, OST_CLK_OTHER} ost_cpu_clk_t;

endpackage

// *** ost_edge_sync.sv ***
// Crystal edge detector: three-stage pin synchroniser, one-cycle rising-edge pulse.
// Assumes each crystal level lasts at least two system cycles.
`timescale 1ns/1ps
module ost_edge_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edge
  input wire logic pin,
  output logic rise
);

  logic s1_r, s2_r, s3_r, lvl_r, rise_r;
  logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt, rise_nxt;

  always_comb begin
    s1_nxt = pin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    // Only the second and third stages are compared
    // A level counts once both agree, so a glitch in stage two is ignored
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
    rise_nxt = s2_r & s3_r & ~lvl_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;

endmodule

// *** ost_xtal_model.sv ***
// Crystal oscillator model for the settle timer.
// Assumes the system clock paces it; the pin rests low when stopped.
`timescale 1ns/1ps
module ost_xtal_model #(
  parameter int HALF = 2
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic run,
  // Crystal pin
  output logic pin
);
  int ph = 0;
  initial pin = 1'b0;
  // No free-running clock: a stopped crystal shows no edges at all
  always @(posedge sys_clk) begin
    if (!run) begin
      pin <= 1'b0;
      ph <= 0;
    end else if (ph == HALF - 1) begin
      pin <= ~pin;
      ph <= 0;
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

// *** tb_ost_settle_timer.sv ***
// Testbench for the crystal settle timer.
// Assumes the crystal model paces edges every 4 system cycles.
`timescale 1ns/1ps
module tb_ost_settle_timer;
  import ost_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  ost_bus_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid, hold, done, pin;
  logic run = 1'b0;
  logic stp = 1'b0;
  logic rel = 1'b0;
  logic halt = 1'b0;
  ost_cpu_clk_t csel = OST_CLK_CRYSTAL;
  int n_fail = 0;
  int tests_run = 0;
  int edges = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge pin) edges++;
  ost_xtal_model #(.HALF(2)) xtal (.sys_clk(sys_clk), .run(run), .pin(pin));
  ost_settle_timer dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .BUS_REQ(req), .BUS_RDATA(rdata),
    .BUS_RVALID(rvalid), .CRYSTAL_PIN(pin), .STOP_ENTRY(stp), .STOP_RELEASE(rel),
    .MAIN_OSC_HALT(halt), .CPU_CLK_SEL(csel), .CPU_HOLD(hold), .SETTLE_DONE(done));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One bus cycle; reads check the answer one cycle later
  task automatic bus(input logic w, input logic b, input logic [2:0] p, input logic [15:0] a,
                     input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    req <= '{rd: !w, wr: w, bit_acc: b, bit_pos: p, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1;
    if (!w) begin
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
    end
  endtask
  task automatic pulse_stop(input logic release_it);
    @(posedge sys_clk);
    if (release_it) rel <= 1'b1;
    else stp <= 1'b1;
    @(posedge sys_clk);
    rel <= 1'b0;
    stp <= 1'b0;
    #1;
  endtask
  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim && done !== 1'b1; i++) cyc(1);
    if (i == lim) begin
      n_fail++;
      $display("BAD %0t no settle", $time);
      complete_run();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h00);
    bus(0, 0, 0, OST_ADDR_SELECT, 0, 8'h05);
    bus(0, 0, 0, 16'hffa5, 0, 8'h00);
    bus(1, 0, 0, OST_ADDR_STATUS, 8'hff, 0);
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h00);
    bus(1, 1, 0, OST_ADDR_SELECT, 8'h01, 0);
    bus(0, 0, 0, OST_ADDR_SELECT, 0, 8'h05);
    bus(1, 0, 0, OST_ADDR_SELECT, 8'hf9, 0);
    bus(0, 0, 0, OST_ADDR_SELECT, 0, 8'h01);
  endtask
  task automatic t_crystal();
    pulse_stop(0);
    edges = 0;
    @(posedge sys_clk);
    run <= 1'b1;
    pulse_stop(1);
    cyc(2);
    chk({7'h00, hold}, 8'h01);
    wait_done(20000);
    chk({7'h00, hold}, 8'h01);
    chk({7'h00, edges >= 2052 && edges <= 2053}, 8'h01);
    cyc(1);
    chk({7'h00, hold}, 8'h00);
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h10);
    cyc(26000);
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h10);
    bus(0, 1, 4, OST_ADDR_STATUS, 0, 8'h01);
    pulse_stop(0);
    chk({7'h00, done}, 8'h00);
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h00);
    @(posedge sys_clk);
    run <= 1'b0;
  endtask
  task automatic t_internal();
    @(posedge sys_clk);
    csel <= OST_CLK_HIGH_INT;
    bus(1, 0, 0, OST_ADDR_SELECT, 8'h02, 0);
    pulse_stop(0);
    @(posedge sys_clk);
    run <= 1'b1;
    pulse_stop(1);
    cyc(2);
    chk({7'h00, hold}, 8'h00);
    wait_done(40000);
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h18);
    @(posedge sys_clk);
    halt <= 1'b1;
    cyc(3);
    bus(0, 0, 0, OST_ADDR_STATUS, 0, 8'h00);
    @(posedge sys_clk);
    run <= 1'b0;
    halt <= 1'b0;
    rst_n <= 1'b0;
    cyc(3);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, 0, 0, OST_ADDR_SELECT, 0, 8'h05);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_crystal();
    t_internal();
    complete_run();
  end
endmodule
